/* File: hdl/hsfs_cfg.svh */
// Offsets, reset values and timing counts of the hot-swap fault sequencer
`ifndef HSFS_CFG_SVH
`define HSFS_CFG_SVH

// Clock and prescaled tick
`define HSFS_CLK_PERIOD_NS   10
`define HSFS_TICK_NS         1000
`define HSFS_TICK_CYC        (`HSFS_TICK_NS / `HSFS_CLK_PERIOD_NS)

// Delays in microseconds, one tick each, and the retry delay as a multiple of startup
`define HSFS_LOCK_DELAY_US   37500
`define HSFS_START_DEF_US    9000
`define HSFS_START_MIN_US    400
`define HSFS_START_MAX_US    50000
`define HSFS_RETRY_MULT      64
`define HSFS_SLOW_MIN_US     110
`define HSFS_SLOW_MAX_US     3000
`define HSFS_LATCH_CLR_US    100
`define HSFS_MON_FILT_US     20
`define HSFS_PG_DELAY_US     750

// Fast trip response bound, rounded down to cycles
`define HSFS_FAST_RESP_NS    260
`define HSFS_FAST_RESP_CYC   (`HSFS_FAST_RESP_NS / `HSFS_CLK_PERIOD_NS)

// Register byte offsets
`define HSFS_CTRL_OFF        8'h00
`define HSFS_START_OFF       8'h04
`define HSFS_STATUS_OFF      8'h08

// Field positions
`define HSFS_CTRL_LATCH_BIT  0
`define HSFS_CTRL_MONL_BIT   1

// Bus responses
`define HSFS_RESP_OKAY       2'h0
`define HSFS_RESP_SLVERR     2'h2

`endif

/* File: hdl/hsfs_pkg.sv */
// Types shared by the hot-swap fault sequencer modules
package hsfs_pkg;

	typedef enum logic [2:0] {
		HSFS_LOCKOUT,
		HSFS_IDLE,
		HSFS_STARTUP,
		HSFS_NORMAL,
		HSFS_RETRY,
		HSFS_LATCHED
	} hsfs_mode_e;

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
		logic [4:0] cnt;
		logic       fault;
	} hsfs_win_s;

	typedef struct packed {
		hsfs_mode_e  st;
		logic [6:0]  pre;
		logic        tick;
		logic [21:0] tmr;
		logic [6:0]  low_cnt;
		logic [1:0]  ok_mask;
		logic [11:0] slow_cnt;
		logic [10:0] meta;
		logic [10:0] sync;
		logic [2:0]  cause;
		logic [1:0]  chg;
		logic [1:0]  rgl;
		logic [1:0]  dis;
		logic        su_sel;
		logic        slow_en;
		logic        pg_drive;
		logic        pg_lvl;
		logic        ctl_lf;
		logic        ctl_lm;
		logic [15:0] t_start;
		logic        aw_rdy;
		logic        w_rdy;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_rdy;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} hsfs_state_s;

endpackage : hsfs_pkg

/* File: hdl/hsfs_win_if.sv */
// Carrier between the sequencer and its window filter
`timescale 1ns/100ps
interface hsfs_win_if;
	logic       tick;
	logic       arm;
	logic [3:0] raw;
	logic       fault;

	modport filt (input tick, input arm, input raw, output fault);
	modport user (output tick, output arm, output raw, input fault);
endinterface : hsfs_win_if

/* File: hdl/hsfs_win_filt.sv */
// Window comparator synchroniser and glitch filter
`timescale 1ns/100ps
`include "hsfs_cfg.svh"
module hsfs_win_filt #(
	parameter logic [4:0] FILT_TICKS = 5'(`HSFS_MON_FILT_US)
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	hsfs_win_if.filt  win
);
	hsfs_pkg::hsfs_win_s s;
	hsfs_pkg::hsfs_win_s next_s;

	// Excursion must stay out of window for the whole filter time
	always_comb
	begin
		next_s      = s;
		next_s.meta = win.raw;
		next_s.sync = s.meta;
		if (!win.arm || s.sync == 4'h0)
			next_s.cnt = 5'h00;
		else if (win.tick && s.cnt < FILT_TICKS)
			next_s.cnt = s.cnt + 5'h01;
		next_s.fault = win.arm && (s.sync != 4'h0) && (s.cnt >= FILT_TICKS);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign win.fault = s.fault;

	a_filt_min_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(s.fault) |-> $past(s.cnt) >= FILT_TICKS)
		else $error("window fault raised before filter time");
endmodule : hsfs_win_filt

/* File: hdl/hsfs_seq.sv */
// Hot-swap fault sequencer top with its register slave
`timescale 1ns/100ps
`include "hsfs_cfg.svh"
// What this block does
// - Slow comparator ignored during startup
// - Startup end enables slow comparator, normal
// - Slow trip qualified 110us to 3ms
// - Slow fault: power-good low, strong discharge
// - Fast trip in startup regulates gate
// - Fast trip in normal faults at once
// - Gates off until lockout delay qualified
// - Both supplies low restarts lockout, startup
// - Latched: clear on enable off, 100us dip
// - Autoretry restarts after 64 startup intervals
// - Enable low never shortens retry delay
// - Supply dip aborts retry delay
// - Window monitors armed only after startup
// - Latching monitor latches, discharges both gates
// - Reporting monitor only lowers power-good
// - Window excursions under 20us ignored
// - Power-good low when off or faulted
// - Power-good released 0.75ms into normal
// - Startup needs lockout, enable, no fault
// - Startup interval 9ms, settable 0.4-50ms
// - Three-level enable selects channels
module hsfs_seq #(
	parameter int unsigned TICK_CYCLES  = `HSFS_TICK_CYC,
	parameter int unsigned LOCK_US      = `HSFS_LOCK_DELAY_US,
	parameter int unsigned SLOW_MIN_US  = `HSFS_SLOW_MIN_US,
	parameter int unsigned SLOW_MAX_US  = `HSFS_SLOW_MAX_US,
	parameter int unsigned LATCH_CLR_US = `HSFS_LATCH_CLR_US,
	parameter int unsigned PG_US        = `HSFS_PG_DELAY_US,
	parameter int unsigned MON_FILT_US  = `HSFS_MON_FILT_US
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        supply1_lockout_ok_i,
	input  wire logic        supply2_lockout_ok_i,
	input  wire logic        enable_above_off_i,
	input  wire logic        enable_ch1_i,
	input  wire logic        enable_ch2_i,
	input  wire logic [1:0]  slow_trip_i,
	input  wire logic [1:0]  slow_trip_hard_i,
	input  wire logic [1:0]  fast_trip_i,
	input  wire logic [1:0]  out1_window_input_i,
	input  wire logic [1:0]  out2_window_input_i,
	output logic [1:0]       gate_charge_o,
	output logic [1:0]       gate_regulate_o,
	output logic [1:0]       gate_discharge_o,
	output logic             startup_limit_sel_o,
	output logic             slow_cmp_enable_o,
	output logic             power_ok_status_o,
	output logic             power_ok_status_oe_o,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	hsfs_pkg::hsfs_state_s s;
	hsfs_pkg::hsfs_state_s next_s;
	hsfs_win_if            win ();

	logic        sup1;
	logic        sup2;
	logic        on_min;
	logic        on1;
	logic        on2;
	logic [1:0]  slow_s;
	logic [1:0]  hard_s;
	logic [1:0]  fast_s;
	logic        both_low;
	logic [11:0] slow_thr;
	logic        slow_hit;
	logic        fault_oc;
	logic        mon_lat;
	logic [21:0] start_ticks;
	logic [21:0] retry_ticks;
	logic [1:0]  reg_req;
	logic        running;
	logic [15:0] start_wr;

	// Synchronised pin view, second stage only
	assign fast_s   = s.sync[1:0];
	assign slow_s   = s.sync[3:2];
	assign hard_s   = s.sync[5:4];
	assign on2      = s.sync[6];
	assign on1      = s.sync[7];
	assign on_min   = s.sync[8];
	assign sup1     = s.sync[9];
	assign sup2     = s.sync[10];
	assign both_low = !sup1 && !sup2;

	// Larger overdrive qualifies sooner
	assign slow_thr    = (hard_s != 2'h0) ? 12'(SLOW_MIN_US) : 12'(SLOW_MAX_US);
	assign slow_hit    = (slow_s != 2'h0) && (s.slow_cnt >= slow_thr);
	assign fault_oc    = slow_hit || (fast_s != 2'h0);
	assign mon_lat     = win.fault && s.ctl_lm;
	assign start_ticks = 22'(s.t_start);
	assign retry_ticks = 22'(s.t_start) * 22'(`HSFS_RETRY_MULT);
	assign running     = (s.st == hsfs_pkg::HSFS_STARTUP) || (s.st == hsfs_pkg::HSFS_NORMAL);
	assign reg_req     = (s.st == hsfs_pkg::HSFS_STARTUP) ? (fast_s & {on2, on1}) : 2'h0;

	// Window filter feed; raw pins are synchronised inside
	assign win.tick = s.tick;
	assign win.arm  = (s.st == hsfs_pkg::HSFS_NORMAL);
	assign win.raw  = {out2_window_input_i, out1_window_input_i};

	hsfs_win_filt #(
		.FILT_TICKS (5'(MON_FILT_US))
	) u_win (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.win       (win.filt)
	);

	// Start time write with byte lanes, clamped to the legal span
	always_comb
	begin
		start_wr = s.t_start;
		if (s.wstrb[0])
			start_wr[7:0] = s.wdata[7:0];
		if (s.wstrb[1])
			start_wr[15:8] = s.wdata[15:8];
		if (start_wr < 16'(`HSFS_START_MIN_US))
			start_wr = 16'(`HSFS_START_MIN_US);
		else if (start_wr > 16'(`HSFS_START_MAX_US))
			start_wr = 16'(`HSFS_START_MAX_US);
	end

	// Sequencer, timers and register slave in one next-state image
	always_comb
	begin
		next_s      = s;
		next_s.meta = {supply2_lockout_ok_i, supply1_lockout_ok_i, enable_above_off_i, enable_ch1_i,
			enable_ch2_i, slow_trip_hard_i, slow_trip_i, fast_trip_i};
		next_s.sync = s.meta;

		// One microsecond tick drives every delay
		next_s.tick = 1'b0;
		if (s.pre >= 7'(TICK_CYCLES - 1))
		begin
			next_s.pre  = 7'h00;
			next_s.tick = 1'b1;
		end
		else
			next_s.pre = s.pre + 7'h01;

		// State timer saturates instead of wrapping
		if (s.tick && s.tmr != 22'h3FFFFF)
			next_s.tmr = s.tmr + 22'h000001;

		// Dip timer counts only supplies that were good at the fault
		if ((s.ok_mask & ~{sup2, sup1}) == 2'h0)
			next_s.low_cnt = 7'h00;
		else if (s.tick && s.low_cnt < 7'(LATCH_CLR_US))
			next_s.low_cnt = s.low_cnt + 7'h01;

		// Overcurrent integrator runs only in normal operation
		if (s.st == hsfs_pkg::HSFS_NORMAL && slow_s != 2'h0)
		begin
			if (s.tick && s.slow_cnt < 12'(SLOW_MAX_US))
				next_s.slow_cnt = s.slow_cnt + 12'h001;
		end
		else
			next_s.slow_cnt = 12'h000;

		case (s.st)
			hsfs_pkg::HSFS_LOCKOUT:
			begin
				if (sup1 || sup2)
				begin
					if (s.tmr >= 22'(LOCK_US))
						next_s.st = hsfs_pkg::HSFS_IDLE;
				end
				else
					next_s.tmr = 22'h000000;
			end
			hsfs_pkg::HSFS_IDLE:
			begin
				if (on1)
				begin
					next_s.st    = hsfs_pkg::HSFS_STARTUP;
					next_s.cause = 3'h0;
				end
			end
			hsfs_pkg::HSFS_STARTUP:
			begin
				if (!on1)
					next_s.st = hsfs_pkg::HSFS_IDLE;
				else if (s.tmr >= start_ticks)
					next_s.st = hsfs_pkg::HSFS_NORMAL;
			end
			hsfs_pkg::HSFS_NORMAL:
			begin
				if (fault_oc || mon_lat)
				begin
					// Monitor latch wins over autoretry
					next_s.st      = (s.ctl_lf || mon_lat) ? hsfs_pkg::HSFS_LATCHED : hsfs_pkg::HSFS_RETRY;
					next_s.cause   = {mon_lat, fast_s != 2'h0, slow_hit};
					next_s.ok_mask = {sup2, sup1};
					next_s.low_cnt = 7'h00;
				end
				else if (!on1)
					next_s.st = hsfs_pkg::HSFS_IDLE;
			end
			hsfs_pkg::HSFS_RETRY:
			begin
				// Enable level is deliberately not looked at here
				if (s.tmr >= retry_ticks)
					next_s.st = hsfs_pkg::HSFS_IDLE;
			end
			hsfs_pkg::HSFS_LATCHED:
			begin
				if (!on_min)
					next_s.st = hsfs_pkg::HSFS_IDLE;
				else if (s.low_cnt >= 7'(LATCH_CLR_US))
					next_s.st = hsfs_pkg::HSFS_LOCKOUT;
			end
			default:
				next_s.st = hsfs_pkg::HSFS_LOCKOUT;
		endcase

		// Loss of both supplies restarts qualification, latch waits for dip time
		if (both_low && s.st != hsfs_pkg::HSFS_LATCHED)
			next_s.st = hsfs_pkg::HSFS_LOCKOUT;
		if (next_s.st != s.st)
			next_s.tmr = 22'h000000;

		// Gate commands per channel
		next_s.chg     = running ? ({on2, on1} & ~reg_req) : 2'h0;
		next_s.rgl     = reg_req;
		next_s.dis     = (s.st == hsfs_pkg::HSFS_RETRY || s.st == hsfs_pkg::HSFS_LATCHED) ? 2'h3 : 2'h0;
		next_s.su_sel  = (s.st == hsfs_pkg::HSFS_STARTUP);
		next_s.slow_en = (s.st == hsfs_pkg::HSFS_NORMAL);

		// Power-good released only in settled fault-free normal operation
		next_s.pg_drive = !((s.st == hsfs_pkg::HSFS_NORMAL) && (s.tmr >= 22'(PG_US)) && on1 &&
			!win.fault && !fault_oc);
		next_s.pg_lvl   = 1'b0;

		// Write address and data are taken in either order
		if (s_axi_awvalid && s.aw_rdy)
		begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.w_rdy)
		begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = `HSFS_RESP_OKAY;
			case (s.awaddr)
				`HSFS_CTRL_OFF:
				begin
					if (s.wstrb[0])
					begin
						next_s.ctl_lf = s.wdata[`HSFS_CTRL_LATCH_BIT];
						next_s.ctl_lm = s.wdata[`HSFS_CTRL_MONL_BIT];
					end
				end
				`HSFS_START_OFF:
					next_s.t_start = start_wr;
				`HSFS_STATUS_OFF:
					next_s.bresp = `HSFS_RESP_OKAY;
				default:
					next_s.bresp = `HSFS_RESP_SLVERR;
			endcase
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		next_s.aw_rdy = !next_s.aw_got && !next_s.bvalid;
		next_s.w_rdy  = !next_s.w_got && !next_s.bvalid;

		// Read data are captured at address acceptance
		if (s_axi_arvalid && s.ar_rdy)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = `HSFS_RESP_OKAY;
			case (s_axi_araddr)
				`HSFS_CTRL_OFF:
					next_s.rdata = {30'h00000000, s.ctl_lm, s.ctl_lf};
				`HSFS_START_OFF:
					next_s.rdata = {16'h0000, s.t_start};
				`HSFS_STATUS_OFF:
					next_s.rdata = {22'h000000, s.cause, s.pg_drive, sup2, sup1, win.fault, s.st};
				default:
				begin
					next_s.rdata = 32'h00000000;
					next_s.rresp = `HSFS_RESP_SLVERR;
				end
			endcase
		end
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		next_s.ar_rdy = !next_s.rvalid;
	end

	// Power-good held low through reset
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s          <= '0;
			s.st       <= hsfs_pkg::HSFS_LOCKOUT;
			s.t_start  <= 16'(`HSFS_START_DEF_US);
			s.pg_drive <= 1'b1;
		end
		else
			s <= next_s;
	end

	// Every output straight from the state image
	assign gate_charge_o        = s.chg;
	assign gate_regulate_o      = s.rgl;
	assign gate_discharge_o     = s.dis;
	assign startup_limit_sel_o  = s.su_sel;
	assign slow_cmp_enable_o    = s.slow_en;
	assign power_ok_status_o    = s.pg_lvl;
	assign power_ok_status_oe_o = s.pg_drive;
	assign s_axi_awready        = s.aw_rdy;
	assign s_axi_wready         = s.w_rdy;
	assign s_axi_bvalid         = s.bvalid;
	assign s_axi_bresp          = s.bresp;
	assign s_axi_arready        = s.ar_rdy;
	assign s_axi_rvalid         = s.rvalid;
	assign s_axi_rdata          = s.rdata;
	assign s_axi_rresp          = s.rresp;

	a_slow_held_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_STARTUP) |=> (s.slow_cnt == 12'h000))
		else $error("slow integrator ran during startup");

	a_slow_enabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_NORMAL) |=> s.slow_en)
		else $error("slow comparator not enabled in normal");

	a_slow_floor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(s.cause[0]) |-> ($past(s.slow_cnt) >= 12'(SLOW_MIN_US)))
		else $error("slow fault before minimum qualify time");

	a_fault_discharge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_RETRY || s.st == hsfs_pkg::HSFS_LATCHED) |=> (s.dis == 2'h3 && s.pg_drive))
		else $error("fault state without strong discharge");

	a_fast_response: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_NORMAL && fast_s != 2'h0) |-> ##2 (s.dis == 2'h3 && s.chg == 2'h0))
		else $error("fast trip not answered in time");

	a_startup_regulate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_STARTUP && fast_s[0] && on1) |=> (s.rgl[0] && !s.chg[0] && s.dis == 2'h0))
		else $error("startup fast trip did not regulate");

	a_lockout_gates: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_LOCKOUT) |=> (s.chg == 2'h0))
		else $error("gate charged during lockout");

	a_dip_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(both_low && s.st != hsfs_pkg::HSFS_LATCHED) |=> (s.st == hsfs_pkg::HSFS_LOCKOUT && s.tmr == 22'h000000))
		else $error("supply dip did not restart lockout");

	a_retry_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_RETRY && !on_min && !both_low && s.tmr < retry_ticks) |=>
		(s.st == hsfs_pkg::HSFS_RETRY))
		else $error("enable low shortened retry delay");

	a_pg_low_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st != hsfs_pkg::HSFS_NORMAL || !on1) |=> s.pg_drive)
		else $error("power-good released outside normal");

	a_pg_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(s.pg_drive) |-> ($past(s.st) == hsfs_pkg::HSFS_NORMAL && $past(s.tmr) >= 22'(PG_US)))
		else $error("power-good released too early");

	a_report_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s.st == hsfs_pkg::HSFS_NORMAL && win.fault && !s.ctl_lm && !fault_oc && on1) |=>
		(s.st == hsfs_pkg::HSFS_NORMAL && s.pg_drive))
		else $error("reporting monitor disturbed gates");
endmodule : hsfs_seq

/* File: dv/hsfs_far_model.sv */
// Far-side model of supplies, enable divider, current sense and output monitors
`timescale 1ns/100ps
module hsfs_far_model (
	input  wire logic [1:0] sup_i,
	input  wire logic [1:0] en_lvl_i,
	input  wire logic       slow_i,
	input  wire logic       hard_i,
	input  wire logic       fast_i,
	input  wire logic [1:0] win_i,
	input  wire logic [1:0] dis_i,
	output logic [1:0]      sup_o,
	output logic [2:0]      en_o,
	output logic [1:0]      slow_o,
	output logic [1:0]      hard_o,
	output logic [1:0]      fast_o,
	output logic [1:0]      win1_o,
	output logic [1:0]      win2_o
);
	logic cut;
	// A strongly discharged gate stops load current, so sense trips fall away
	assign cut = |dis_i;
	assign sup_o = sup_i;
	// Enable thresholds nest: a higher level implies each lower one
	assign en_o = {en_lvl_i == 2'h3, en_lvl_i >= 2'h2, en_lvl_i != 2'h0};
	// Only channel one carries the overload
	assign slow_o = {1'b0, slow_i & ~cut};
	assign hard_o = {1'b0, hard_i & ~cut};
	assign fast_o = {1'b0, fast_i & ~cut};
	// Output one sags below its window, output two rises above
	assign win1_o = {1'b0, win_i[0]};
	assign win2_o = {win_i[1], 1'b0};
endmodule : hsfs_far_model

/* File: dv/tb_top.sv */
// Self-checking bench for the hot-swap fault sequencer
`timescale 1ns/100ps
module tb_top;
	localparam int ST = 400;
	localparam int LK = 20;
	localparam int PG = 5;
	typedef struct packed {
		logic [1:0]  r;
		logic [31:0] d;
		logic [31:0] m;
	} hsfs_exp_s;
	logic        clk_i, sys_rst_i, slow, hard, fast, sel, scen;
	logic [1:0]  sup, en_lvl, win, dis, chg, rgl, sp, hp, fp, w1, w2, su;
	logic [2:0]  ep;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pg_oe, pg_lvl;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	hsfs_exp_s   rq[$];
	logic [1:0]  wq[$];
	int          err_count, checks_done;

	hsfs_far_model i_far (.sup_i(sup), .en_lvl_i(en_lvl), .slow_i(slow), .hard_i(hard), .fast_i(fast),
		.win_i(win), .dis_i(dis), .sup_o(su), .en_o(ep), .slow_o(sp), .hard_o(hp), .fast_o(fp),
		.win1_o(w1), .win2_o(w2));
	// Short timing so a full retry fits the run
	hsfs_seq #(.TICK_CYCLES(2), .LOCK_US(LK), .SLOW_MIN_US(3), .SLOW_MAX_US(10), .LATCH_CLR_US(4),
		.PG_US(PG), .MON_FILT_US(3)) i_dut (.clk_i, .sys_rst_i, .supply1_lockout_ok_i(su[0]),
		.supply2_lockout_ok_i(su[1]), .enable_above_off_i(ep[0]), .enable_ch1_i(ep[1]),
		.enable_ch2_i(ep[2]), .slow_trip_i(sp), .slow_trip_hard_i(hp), .fast_trip_i(fp),
		.out1_window_input_i(w1), .out2_window_input_i(w2), .gate_charge_o(chg), .gate_regulate_o(rgl),
		.gate_discharge_o(dis), .startup_limit_sel_o(sel), .slow_cmp_enable_o(scen),
		.power_ok_status_o(pg_lvl), .power_ok_status_oe_o(pg_oe), .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp);

	// Free-running 100 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic cmp_pin(input logic [3:0] g, input logic [3:0] e);
		chk({30'h0, g}, {30'h0, e});
	endtask : cmp_pin
	task automatic cmp_rd(input hsfs_exp_s e);
		chk({s_axi_rresp, s_axi_rdata & e.m}, {e.r, e.d & e.m});
	endtask : cmp_rd
	task automatic cmp_wr(input logic [1:0] e);
		chk({32'h0, s_axi_bresp}, {32'h0, e});
	endtask : cmp_wr
	task automatic tk(input int n);
		repeat (n * 2) @(posedge clk_i);
	endtask : tk
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		wq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		// Upper lanes and protection are random: no register may depend on them
		s_axi_wstrb <= {2'($urandom), 2'h3};
		s_axi_awprot <= 3'($urandom);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!(s_axi_bvalid && s_axi_bready) && n < 100);
		s_axi_bready <= 1'b0;
		err_count += int'(n >= 100);
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] e);
		int n;
		n = 0;
		rq.push_back('{e, d, m});
		s_axi_araddr <= a;
		s_axi_arprot <= 3'($urandom);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!(s_axi_rvalid && s_axi_rready) && n < 100);
		s_axi_rready <= 1'b0;
		err_count += int'(n >= 100);
		@(posedge clk_i);
	endtask : rd
	// State field of the status word
	task automatic st(input logic [31:0] x);
		rd(8'h08, x, 32'h7, 2'h0);
	endtask : st
	task automatic results;
		$display("checks_done=%0d err_count=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Scoreboard: the oldest note meets each bus answer
	always @(posedge clk_i)
	begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready && wq.size() > 0)
			cmp_wr(wq.pop_front());
		if (s_axi_rvalid === 1'b1 && s_axi_rready && rq.size() > 0)
			cmp_rd(rq.pop_front());
	end

	// Watchdog well beyond one full retry delay
	initial
	begin
		repeat (90000) @(posedge clk_i);
		err_count++;
		results();
	end

	// Main sequence
	initial
	begin
		{sys_rst_i, sup, en_lvl, slow, hard, fast, win} = {1'b1, 9'h0};
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		v = $urandom(25047);
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		cmp_pin({chg, dis[0], pg_oe}, 4'h1);
		rd(8'h00, 32'h0, 32'hFFFF_FFFF, 2'h0);
		rd(8'h04, 32'h2328, 32'hFFFF, 2'h0);
		wr(8'h10, $urandom, 2'h2);
		rd(8'h0C, 32'h0, 32'hFFFF_FFFF, 2'h2);
		wr(8'h08, $urandom, 2'h0);
		st(32'h0);
		v = 32'(400 + $urandom_range(49600));
		wr(8'h04, v, 2'h0);
		rd(8'h04, v, 32'hFFFF, 2'h0);
		wr(8'h04, 32'h64, 2'h0);
		rd(8'h04, 32'h190, 32'hFFFF, 2'h0);
		sup <= 2'h1;
		tk(LK - 4);
		st(32'h0);
		tk(6);
		st(32'h1);
		en_lvl <= 2'h2;
		tk(3);
		st(32'h2);
		cmp_pin({chg, sel, pg_oe}, 4'h7);
		{slow, hard, win} <= 4'hD;
		tk(10);
		rd(8'h08, 32'h2, 32'hF, 2'h0);
		fast <= 1'b1;
		tk(2);
		cmp_pin({2'h0, rgl}, 4'h1);
		st(32'h2);
		{slow, hard, fast, win} <= 5'h0;
		tk(ST);
		st(32'h3);
		cmp_pin({1'b0, scen, chg}, 4'h5);
		tk(PG + 2);
		cmp_pin({2'h0, pg_lvl, pg_oe}, 4'h0);
		en_lvl <= 2'h3;
		tk(2);
		cmp_pin({2'h0, chg}, 4'h3);
		en_lvl <= 2'h1;
		tk(3);
		cmp_pin({chg, 1'b0, pg_oe}, 4'h1);
		en_lvl <= 2'h3;
		tk(ST + PG + 6);
		win <= 2'h1;
		tk(1);
		win <= 2'h0;
		tk(4);
		cmp_pin({3'h0, pg_oe}, 4'h0);
		win <= 2'h2;
		tk(7);
		cmp_pin({dis, pg_lvl, pg_oe}, 4'h1);
		win <= 2'h0;
		tk(3);
		cmp_pin({3'h0, pg_oe}, 4'h0);
		fast <= 1'b1;
		repeat (27) @(posedge clk_i);
		cmp_pin({dis, 1'b0, pg_oe}, 4'hD);
		fast <= 1'b0;
		st(32'h4);
		en_lvl <= 2'h0;
		tk(5);
		st(32'h4);
		{en_lvl, sup} <= 4'hC;
		tk(3);
		st(32'h0);
		sup <= 2'h2;
		tk(LK + 4);
		st(32'h2);
		tk(ST + PG + 4);
		slow <= 1'b1;
		tk(7);
		st(32'h3);
		tk(5);
		st(32'h4);
		slow <= 1'b0;
		tk(64 * ST - 20);
		st(32'h4);
		tk(30);
		st(32'h2);
		wr(8'h00, 32'h1, 2'h0);
		tk(ST + PG + 4);
		{slow, hard} <= 2'h3;
		tk(7);
		st(32'h5);
		cmp_pin({dis, 1'b0, pg_oe}, 4'hD);
		{slow, hard, en_lvl} <= 4'h0;
		tk(3);
		st(32'h1);
		wr(8'h00, 32'h2, 2'h0);
		en_lvl <= 2'h3;
		tk(ST + PG + 4);
		win <= 2'h1;
		tk(7);
		st(32'h5);
		cmp_pin({dis, 2'h0}, 4'hC);
		{win, sup} <= 4'h0;
		tk(1);
		sup <= 2'h2;
		tk(3);
		st(32'h5);
		sup <= 2'h0;
		tk(7);
		st(32'h0);
		results();
	end
endmodule : tb_top
